// ### rtl/jdp_pkg.sv
// Constants, state codes and helpers for the test and debug port pins
//
// Operation
// - The debugger supplies a gated test clock that paces the test logic and all serial shifting.
// - The test data input is taken as the serial stream on each rising test clock edge.
// - The mode select input is taken on each rising test clock edge to advance the TAP controller.
// - The test data output is driven only in the Shift-IR and Shift-DR states; the code still drives it in Exit1-IR/Exit1-DR until that state's falling edge.
// - In every other TAP state the test data output is released to high impedance; the code releases it in Exit1 only at the falling edge.
// - The test data output changes on the falling test clock edge so it is stable at the next rise.
// - A low test reset puts the TAP controller in reset regardless of test clock and mode select.
// - The debug event line is open-drain and active low; the device only ever pulls it low.
// - An outside controller pulling the debug event line low asks the device to enter debug mode.
// - The device pulls the debug event line low to acknowledge it is in debug mode.
// - Undriven, the test clock idles low while data in, mode select and debug event idle high.
package jdp_pkg;

    // ------------------------------------------------------------
    // Sizes and codes
    // ------------------------------------------------------------
    localparam int        JDP_IR_W       = 4;
    localparam int        JDP_DR_W       = 8;
    localparam int        JDP_FIFO_D     = 32;
    localparam logic [3:0] JDP_IR_BYPASS = 4'hF;
    localparam logic [3:0] JDP_IR_DATA   = 4'h4;
    localparam logic [3:0] JDP_IR_CAPT   = 4'h1;

    // ------------------------------------------------------------
    // Pin synchroniser layout and idle levels
    // ------------------------------------------------------------
    localparam int         JDP_PIN_TCK  = 0;
    localparam int         JDP_PIN_TMS  = 1;
    localparam int         JDP_PIN_TDI  = 2;
    localparam int         JDP_PIN_TRST = 3;
    localparam int         JDP_PIN_DE   = 4;
    localparam logic [4:0] JDP_PIN_IDLE = 5'h1E;

    // ------------------------------------------------------------
    // TAP controller states
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        JDP_TLR    = 16'h0001,
        JDP_RTI    = 16'h0002,
        JDP_SEL_DR = 16'h0004,
        JDP_CAP_DR = 16'h0008,
        JDP_SH_DR  = 16'h0010,
        JDP_EX1_DR = 16'h0020,
        JDP_PA_DR  = 16'h0040,
        JDP_EX2_DR = 16'h0080,
        JDP_UPD_DR = 16'h0100,
        JDP_SEL_IR = 16'h0200,
        JDP_CAP_IR = 16'h0400,
        JDP_SH_IR  = 16'h0800,
        JDP_EX1_IR = 16'h1000,
        JDP_PA_IR  = 16'h2000,
        JDP_EX2_IR = 16'h4000,
        JDP_UPD_IR = 16'h8000
    } jdp_tap_t;

    function automatic jdp_tap_t jdp_tap_next(input jdp_tap_t st, input logic m);
        unique case (st)
            JDP_TLR:    jdp_tap_next = m ? JDP_TLR    : JDP_RTI;
            JDP_RTI:    jdp_tap_next = m ? JDP_SEL_DR : JDP_RTI;
            JDP_SEL_DR: jdp_tap_next = m ? JDP_SEL_IR : JDP_CAP_DR;
            JDP_CAP_DR: jdp_tap_next = m ? JDP_EX1_DR : JDP_SH_DR;
            JDP_SH_DR:  jdp_tap_next = m ? JDP_EX1_DR : JDP_SH_DR;
            JDP_EX1_DR: jdp_tap_next = m ? JDP_UPD_DR : JDP_PA_DR;
            JDP_PA_DR:  jdp_tap_next = m ? JDP_EX2_DR : JDP_PA_DR;
            JDP_EX2_DR: jdp_tap_next = m ? JDP_UPD_DR : JDP_SH_DR;
            JDP_UPD_DR: jdp_tap_next = m ? JDP_SEL_DR : JDP_RTI;
            JDP_SEL_IR: jdp_tap_next = m ? JDP_TLR    : JDP_CAP_IR;
            JDP_CAP_IR: jdp_tap_next = m ? JDP_EX1_IR : JDP_SH_IR;
            JDP_SH_IR:  jdp_tap_next = m ? JDP_EX1_IR : JDP_SH_IR;
            JDP_EX1_IR: jdp_tap_next = m ? JDP_UPD_IR : JDP_PA_IR;
            JDP_PA_IR:  jdp_tap_next = m ? JDP_EX2_IR : JDP_PA_IR;
            JDP_EX2_IR: jdp_tap_next = m ? JDP_UPD_IR : JDP_SH_IR;
            JDP_UPD_IR: jdp_tap_next = m ? JDP_SEL_DR : JDP_RTI;
            default:    jdp_tap_next = JDP_TLR;
        endcase
    endfunction

endpackage

// ### rtl/jdp_fifo.sv
// Word FIFO with a registered read stage
module jdp_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          ov_r, ov_nxt;
    logic [W-1:0]  od_r, od_nxt;
    logic          push, pop;

    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = ov_r;
    assign out_data  = od_r;

    always_comb begin
        push    = in_valid && in_ready;
        pop     = (cnt_r != '0) && (!ov_r || out_ready);
        wp_nxt  = push ? ((wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? ((rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        ov_nxt  = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
        od_nxt  = pop ? mem[rp_r] : od_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            ov_r  <= 1'b0;
            od_r  <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            ov_r  <= ov_nxt;
            od_r  <= od_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    property p_full_refuses;
        @(posedge clk) disable iff (sys_rst)
        (cnt_r == (AW+1)'(D) && !pop) |=> (cnt_r == (AW+1)'(D));
    endproperty
    a_full_refuses: assert property (p_full_refuses) else $error("fifo count moved while full");

    property p_out_hold;
        @(posedge clk) disable iff (sys_rst)
        (out_valid && !out_ready) |=> out_valid && $stable(out_data);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("fifo output dropped before taken");
endmodule

// ### rtl/jdp_port.sv
// Test access port state machine, serial data path and debug event line
module jdp_port
    import jdp_pkg::*;
#(
    parameter int DW = JDP_DR_W,
    parameter int FD = JDP_FIFO_D
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          tck,
    input  wire logic          tms,
    input  wire logic          tdi,
    input  wire logic          trst_n,
    output logic               tdo_o,
    output logic               tdo_oe_n,
    input  wire logic          debug_event_n_i,
    output logic               debug_event_n_o,
    output logic               debug_event_n_oe_n,
    input  wire logic          dbg_entered,
    output logic               dbg_req,
    output logic               overflow,
    output logic               rx_valid,
    input  wire logic          rx_ready,
    output logic [DW-1:0]      rx_data
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] s1_r, s2_r;
    logic       tck_d_r, de_d_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r    <= JDP_PIN_IDLE;
            s2_r    <= JDP_PIN_IDLE;
            tck_d_r <= 1'b0;
            de_d_r  <= 1'b1;
        end else begin
            s1_r    <= {debug_event_n_i, trst_n, tdi, tms, tck};
            s2_r    <= s1_r;
            tck_d_r <= s2_r[JDP_PIN_TCK];
            de_d_r  <= s2_r[JDP_PIN_DE];
        end
    end

    logic tck_rise, tck_fall, trst_ok, tms_s, tdi_s, de_s;
    assign tck_rise = s2_r[JDP_PIN_TCK] && !tck_d_r;
    assign tck_fall = !s2_r[JDP_PIN_TCK] && tck_d_r;
    assign trst_ok  = s2_r[JDP_PIN_TRST];
    assign tms_s    = s2_r[JDP_PIN_TMS];
    assign tdi_s    = s2_r[JDP_PIN_TDI];
    assign de_s     = s2_r[JDP_PIN_DE];

    // ------------------------------------------------------------
    // TAP controller and shift registers
    // ------------------------------------------------------------
    jdp_tap_t              st_r, st_nxt;
    logic [JDP_IR_W-1:0]   ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
    logic [DW-1:0]         dr_r, dr_nxt, pend_d_r, pend_d_nxt;
    logic                  bp_r, bp_nxt, pend_r, pend_nxt, ovf_r, ovf_nxt;
    logic                  tdo_r, tdo_nxt, oe_n_r, oe_n_nxt;
    logic                  fifo_ready, data_sel, shifting;

    assign data_sel = (ir_r == JDP_IR_DATA);
    assign shifting = (st_r == JDP_SH_IR) || (st_r == JDP_SH_DR);

    always_comb begin
        st_nxt     = st_r;
        ir_sh_nxt  = ir_sh_r;
        ir_nxt     = ir_r;
        dr_nxt     = dr_r;
        bp_nxt     = bp_r;
        pend_d_nxt = pend_d_r;
        ovf_nxt    = ovf_r;
        tdo_nxt    = tdo_r;
        oe_n_nxt   = oe_n_r;
        // A completed word waits here; the TAP cannot be stalled, so
        // a word that finds this slot still busy is lost and flagged.
        pend_nxt   = pend_r && !fifo_ready;
        if (!trst_ok) begin
            st_nxt   = JDP_TLR;
            ir_nxt   = JDP_IR_BYPASS;
            oe_n_nxt = 1'b1;
        end else if (tck_rise) begin
            st_nxt = jdp_tap_next(st_r, tms_s);
            unique case (st_r)
                JDP_TLR: begin
                    ir_nxt = JDP_IR_BYPASS;
                end
                JDP_CAP_IR: begin
                    ir_sh_nxt = JDP_IR_CAPT;
                end
                JDP_SH_IR: begin
                    ir_sh_nxt = {tdi_s, ir_sh_r[JDP_IR_W-1:1]};
                end
                JDP_UPD_IR: begin
                    ir_nxt = ir_sh_r;
                end
                JDP_CAP_DR: begin
                    if (data_sel) begin
                        // Capture reports status; reading it clears the overflow
                        dr_nxt  = DW'({dbg_entered, ovf_r, !fifo_ready});
                        ovf_nxt = 1'b0;
                    end else begin
                        bp_nxt = 1'b0;
                    end
                end
                JDP_SH_DR: begin
                    if (data_sel) begin
                        dr_nxt = {tdi_s, dr_r[DW-1:1]};
                    end else begin
                        bp_nxt = tdi_s;
                    end
                end
                JDP_UPD_DR: begin
                    if (data_sel) begin
                        if (pend_nxt) begin
                            ovf_nxt = 1'b1;
                        end else begin
                            pend_nxt   = 1'b1;
                            pend_d_nxt = dr_r;
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (tck_fall) begin
            oe_n_nxt = !shifting;
            if (st_r == JDP_SH_IR) begin
                tdo_nxt = ir_sh_r[0];
            end else if (st_r == JDP_SH_DR) begin
                tdo_nxt = data_sel ? dr_r[0] : bp_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r     <= JDP_TLR;
            ir_sh_r  <= '0;
            ir_r     <= JDP_IR_BYPASS;
            dr_r     <= '0;
            bp_r     <= 1'b0;
            pend_r   <= 1'b0;
            pend_d_r <= '0;
            ovf_r    <= 1'b0;
            tdo_r    <= 1'b0;
            oe_n_r   <= 1'b1;
        end else begin
            st_r     <= st_nxt;
            ir_sh_r  <= ir_sh_nxt;
            ir_r     <= ir_nxt;
            dr_r     <= dr_nxt;
            bp_r     <= bp_nxt;
            pend_r   <= pend_nxt;
            pend_d_r <= pend_d_nxt;
            ovf_r    <= ovf_nxt;
            tdo_r    <= tdo_nxt;
            oe_n_r   <= oe_n_nxt;
        end
    end

    assign tdo_o    = tdo_r;
    assign tdo_oe_n = oe_n_r;
    assign overflow = ovf_r;

    // ------------------------------------------------------------
    // Received words
    // ------------------------------------------------------------
    jdp_fifo #(
        .W (DW),
        .D (FD)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (pend_r),
        .in_ready  (fifo_ready),
        .in_data   (pend_d_r),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ------------------------------------------------------------
    // Debug event line
    // ------------------------------------------------------------
    logic req_r, req_nxt, de_oe_n_r, de_oe_n_nxt;

    always_comb begin
        de_oe_n_nxt = !dbg_entered;
        // Our own pull-down reads back low, so only a fall seen while
        // released counts as a request.
        req_nxt = de_d_r && !de_s && de_oe_n_r && !dbg_entered;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_r     <= 1'b0;
            de_oe_n_r <= 1'b1;
        end else begin
            req_r     <= req_nxt;
            de_oe_n_r <= de_oe_n_nxt;
        end
    end

    assign dbg_req            = req_r;
    assign debug_event_n_o    = 1'b0;
    assign debug_event_n_oe_n = de_oe_n_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_tms_rise;
        @(posedge clk) disable iff (sys_rst)
        (trst_ok && !tck_rise) |=> $stable(st_r);
    endproperty
    a_tms_rise: assert property (p_tms_rise) else $error("tap moved without tck rise");

    property p_trst;
        @(posedge clk) disable iff (sys_rst)
        !trst_ok |=> (st_r == JDP_TLR) && oe_n_r;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset ignored");

    property p_tdi_take;
        @(posedge clk) disable iff (sys_rst)
        (trst_ok && tck_rise && st_r == JDP_SH_DR && data_sel) |=> dr_r[DW-1] == $past(tdi_s);
    endproperty
    a_tdi_take: assert property (p_tdi_take) else $error("tdi not shifted in");

    property p_tdo_drive;
        @(posedge clk) disable iff (sys_rst)
        (trst_ok && tck_fall && shifting) |=> !tdo_oe_n;
    endproperty
    a_tdo_drive: assert property (p_tdo_drive) else $error("tdo not driven in shift");

    property p_tdo_hiz;
        @(posedge clk) disable iff (sys_rst)
        // Enable drops at the fall after leaving shift, so Exit1 may still drive
        !tdo_oe_n |-> (shifting || st_r == JDP_EX1_IR || st_r == JDP_EX1_DR);
    endproperty
    a_tdo_hiz: assert property (p_tdo_hiz) else $error("tdo driven outside shift");

    property p_tdo_fall;
        @(posedge clk) disable iff (sys_rst)
        (!tck_fall && trst_ok) |=> $stable(tdo_o);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo changed off falling edge");

    property p_ack;
        @(posedge clk) disable iff (sys_rst)
        dbg_entered |=> !debug_event_n_oe_n && !debug_event_n_o;
    endproperty
    a_ack: assert property (p_ack) else $error("debug mode not acknowledged");

    property p_release;
        @(posedge clk) disable iff (sys_rst)
        !dbg_entered |=> debug_event_n_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("event line held low");

    property p_req;
        @(posedge clk) disable iff (sys_rst)
        (de_d_r && !de_s && de_oe_n_r && !dbg_entered) |=> dbg_req ##1 !dbg_req;
    endproperty
    a_req: assert property (p_req) else $error("debug request missed");

    property p_req_sync;
        @(posedge clk) disable iff (sys_rst)
        dbg_req |-> $past(de_d_r) && !$past(de_s);
    endproperty
    a_req_sync: assert property (p_req_sync) else $error("request from unsynced line");

    property p_shift_paced;
        @(posedge clk) disable iff (sys_rst)
        (trst_ok && !tck_rise) |=> $stable(dr_r) && $stable(ir_sh_r);
    endproperty
    a_shift_paced: assert property (p_shift_paced) else $error("shift off test clock");

    c_shift_dr:  cover property (@(posedge clk) st_r == JDP_SH_DR && !tdo_oe_n);
    c_word_push: cover property (@(posedge clk) pend_r && fifo_ready);
    c_overflow:  cover property (@(posedge clk) $rose(ovf_r));
    c_debug_req: cover property (@(posedge clk) dbg_req);
endmodule

// ### testbench/jdp_dbg_model.sv
// Behavioural debugger that drives the test port pins from outside the device
module jdp_dbg_model (
    input  wire logic clk,
    input  wire logic tdo_o,
    input  wire logic tdo_oe_n,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    output logic      ev_pull_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    initial begin
        tck       = 1'b0; // Gated clock stands low between frames
        tms       = 1'b1;
        tdi       = 1'b1;
        trst_n    = 1'b0; // Held with system reset outside a session
        ev_pull_n = 1'b1; // Released: pull-up keeps the line high
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_pin(input logic trst_v, input logic ev_v);
        trst_n    = trst_v; // Need not follow system reset under debug
        ev_pull_n = ev_v;   // Low asks for debug mode
    endtask

    // ------------------------------------------------------------
    // One test clock period of 320 ns
    // ------------------------------------------------------------
    task automatic clock_bit(input logic m, input logic d, output logic o, output logic oe);
        tms = m; // Stable across the rise
        tdi = d;
        wait_clk(4);
        // Released pin floats: show the inverse so a stray sample is caught
        o   = tdo_oe_n ? !tdo_o : tdo_o; // Taken at the rise
        oe  = tdo_oe_n;
        tck = 1'b1;
        wait_clk(4);
        tck = 1'b0;
    endtask

    task automatic tap_reset;
        logic o;
        logic oe;
        repeat (5) clock_bit(1'b1, 1'b1, o, oe);
        clock_bit(1'b0, 1'b1, o, oe);
    endtask

    // From Run-Test/Idle through capture, n shifts, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [7:0] din,
                        output logic [7:0] cap, output logic oe_sh, output logic oe_idle);
        logic o;
        logic oe;
        cap     = 8'h00;
        oe_sh   = 1'b0;
        oe_idle = 1'b1;
        clock_bit(1'b1, 1'b1, o, oe);
        oe_idle &= oe;
        if (ir) begin
            clock_bit(1'b1, 1'b1, o, oe);
            oe_idle &= oe;
        end
        clock_bit(1'b0, 1'b1, o, oe);
        oe_idle &= oe;
        clock_bit(1'b0, 1'b1, o, oe);
        oe_idle &= oe;
        for (int i = 0; i < n; i++) begin
            clock_bit(i == n - 1, din[i], o, oe);
            cap[i] = o;
            oe_sh |= oe;
        end
        clock_bit(1'b1, 1'b1, o, oe);
        oe_idle &= oe;
        clock_bit(1'b0, 1'b1, o, oe);
        oe_idle &= oe;
        tdi = 1'b1;
    endtask
endmodule

// ### testbench/test_jtag_debug_port_pins.sv
// Self-checking bench for the test and debug port pins
module test_jtag_debug_port_pins
    import jdp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk;
    logic       sys_rst;
    logic       dbg_entered;
    logic       rx_ready;
    wire        tck;
    wire        tms;
    wire        tdi;
    wire        trst_n;
    wire        ev_pull_n;
    wire        de_line;
    logic       tdo_o;
    logic       tdo_oe_n;
    logic       de_o;
    logic       de_oe_n;
    logic       dbg_req;
    logic       overflow;
    logic       rx_valid;
    logic [7:0] rx_data;
    int         num_errors;
    int         n_compared;
    int         cycles;

    // Open-drain wire with pull-up: low if either party pulls
    assign de_line = ev_pull_n & (de_oe_n | de_o);

    jdp_dbg_model dbg (
        .clk(clk), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n), .ev_pull_n(ev_pull_n)
    );

    jdp_port #(.DW(8), .FD(32)) uut (
        .clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n),
        .debug_event_n_i(de_line), .debug_event_n_o(de_o),
        .debug_event_n_oe_n(de_oe_n), .dbg_entered(dbg_entered), .dbg_req(dbg_req),
        .overflow(overflow), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Generous ceiling: the whole run needs roughly 4400 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            tally_and_finish;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pop(output logic ok, output logic [7:0] v);
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            if (rx_valid === 1'b1) ok = 1'b1;
            else step(1);
        end
        v = rx_data;
        if (ok) begin
            rx_ready = 1'b1;
            step(1);
            rx_ready = 1'b0;
            step(1);
        end
    endtask

    task automatic count_req(input int n, output int c, output int first);
        c     = 0;
        first = -1;
        for (int i = 0; i < n; i++) begin
            step(1);
            if (dbg_req === 1'b1) begin
                c++;
                if (first < 0) first = i;
            end
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals;
        check(tdo_oe_n, 1'b1);
        check(de_o, 1'b0);
        check(de_oe_n, 1'b1);
        check(de_line, 1'b1);
        check({dbg_req, overflow, rx_valid}, 3'h0);
    endtask

    task automatic t_ir_data_word;
        logic [7:0] cap;
        logic       sh;
        logic       id;
        logic       ok;
        logic [7:0] v;
        dbg.tap_reset();
        dbg.scan(1'b1, 4, JDP_IR_DATA, cap, sh, id);
        check(cap, JDP_IR_CAPT);
        check(sh, 1'b0);
        check(id, 1'b1);
        dbg.scan(1'b0, 8, 8'hA5, cap, sh, id);
        check(cap, 8'h00);
        check({sh, id}, 2'b01);
        pop(ok, v);
        check({ok, v}, 9'h1A5);
    endtask

    // Far side stalls while words pile up past the buffer's depth
    task automatic t_fill_drain;
        logic [7:0] cap;
        logic       sh;
        logic       id;
        logic       ok;
        logic [7:0] v;
        int         cnt;
        for (int i = 0; i < 36; i++) dbg.scan(1'b0, 8, 8'(i), cap, sh, id);
        check(overflow, 1'b1);
        cnt = 0;
        ok  = 1'b1;
        while (ok) begin
            pop(ok, v);
            if (ok) begin
                check(v, 8'(cnt));
                cnt++;
            end
        end
        check(cnt >= 33 && cnt <= 34, 1'b1);
        dbg_entered = 1'b1;
        dbg.scan(1'b0, 8, 8'h3C, cap, sh, id);
        check(cap, 8'h06);
        check(overflow, 1'b0);
        pop(ok, v);
        check({ok, v}, 9'h13C);
        dbg_entered = 1'b0;
        step(2);
    endtask

    task automatic t_debug_event;
        int c;
        int first;
        dbg.set_pin(1'b1, 1'b0);
        count_req(10, c, first);
        check(c, 1);
        check(first >= 1, 1'b1);
        dbg_entered = 1'b1;
        step(2);
        check(de_oe_n, 1'b0);
        dbg.set_pin(1'b1, 1'b1);
        step(2);
        check(de_line, 1'b0);
        dbg.set_pin(1'b1, 1'b0);
        count_req(10, c, first);
        check(c, 0);
        dbg.set_pin(1'b1, 1'b1);
        dbg_entered = 1'b0;
        step(2);
        check({de_oe_n, de_line}, 2'b11);
        step(4);
    endtask

    // Test reset in mid-shift with the test clock stopped
    task automatic t_trst;
        logic       o;
        logic       oe;
        logic [7:0] cap;
        logic       sh;
        logic       id;
        dbg.tap_reset();
        dbg.clock_bit(1'b1, 1'b1, o, oe);
        dbg.clock_bit(1'b0, 1'b1, o, oe);
        dbg.clock_bit(1'b0, 1'b1, o, oe);
        step(5);
        check(tdo_oe_n, 1'b0);
        dbg.set_pin(1'b0, 1'b1);
        step(5);
        check(tdo_oe_n, 1'b1);
        dbg.set_pin(1'b1, 1'b1);
        step(3);
        dbg.clock_bit(1'b0, 1'b1, o, oe);
        dbg.scan(1'b0, 8, 8'hB4, cap, sh, id);
        check(cap, 8'h68);
    endtask

    initial begin
        num_errors  = 0;
        n_compared  = 0;
        cycles      = 0;
        sys_rst     = 1'b1;
        dbg_entered = 1'b0;
        rx_ready    = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        dbg.set_pin(1'b1, 1'b1);
        step(4);
        t_reset_vals();
        t_ir_data_word();
        t_fill_drain();
        t_debug_event();
        t_trst();
        tally_and_finish();
    end
endmodule
